// *** bench/lcc_host.sv ***
// Host model: writes command and parameter bytes on the byte bus.
// Assumes the core samples a byte at every mclk rising edge with the strobe high.
`timescale 1ns/10ps
`default_nettype none
module lcc_host (
  // Clock
  input  wire logic       mclk,
  // Byte bus
  output logic            wr_strobe,
  output logic            data_flag,
  output logic [7:0]      wr_byte
);
  initial begin
    wr_strobe = 1'b0;
    data_flag = 1'b0;
    wr_byte   = 8'h00;
  end
  // Sends one or two bytes back to back, command first; the strobe stays high between them.
  task automatic put(input logic flag, input logic [7:0] b0, input logic [7:0] b1, input int n);
    @(posedge mclk);
    wr_strobe <= 1'b1;
    data_flag <= flag;
    wr_byte   <= b0;
    if (n > 1) begin
      @(posedge mclk);
      wr_byte <= b1;
    end
    @(posedge mclk);
    wr_strobe <= 1'b0;
    // A released bus must not keep showing the last byte.
    wr_byte   <= ~wr_byte;
  endtask
endmodule // lcc_host
`default_nettype wire

// *** bench/lcd_config_command_core_test.sv ***
// Testbench of the configuration core: host command sequences with expected fields.
// Assumes the lcc_host model drives the byte bus; timing events come from here.
`timescale 1ns/10ps
`default_nettype none
module lcd_config_command_core_test;
  import lcc_pkg::*;
  logic mclk, rst, clk_en, hard_reset_low, wr_strobe, data_flag, subframe_head, pixel_load;
  logic polarity_toggle_src, shift_pulse_src, field_marker_src;
  logic [15:0] pixel_word;
  logic [7:0] wr_byte, scan_line_count, contrast_main, contrast_partial, row_window_start, row_window_end;
  logic [7:0] column_window_start, column_window_end, partial_start, partial_end, scroll_start, scroll_end;
  logic [7:0] low_fixed_lines, scroll_first_line;
  logic [5:0] seg_b, boost_clock_div;
  logic [4:0] seg_a, seg_c, invert_block_count;
  logic [3:0] boost1_factor, bias_select, frame_freq_select;
  logic [1:0] subframe_index, duty_select, frame_marker_slot, temp_coef_select, display_pattern;
  logic [1:0] scroll_mode, status_select;
  logic outside_clock_select, ring_clock_on, clock_source_running, com_interleave, seg_color_exchange;
  logic com_scan_reverse, frame_marker_enable, field_marker, shift_pulse_out, polarity_toggle_out;
  logic frame_marker_out, observe_pin, boost_amp_power, boost1_power, boost2_power, boost3_power;
  logic low_power_hold, no_dummy_subgroup, subgroup_invert, subgroup_phase_shift, row_vector_step;
  logic per_frame_invert, half_frame_rate, wide_bus, memory_invert, column_reverse, row_reverse;
  logic row_first_count, read_modify_write_on, display_on, partial_on, partial_mode_sel, partial_dummy;
  logic nv_trim_calibrate_on;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  lcc_core u_dut (.*);
  lcc_host u_host (.mclk(mclk), .wr_strobe(wr_strobe), .data_flag(data_flag), .wr_byte(wr_byte));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // About 120 cycles are needed; the ceiling leaves ample margin.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic defaults();
    chk({duty_select, seg_color_exchange, com_scan_reverse, frame_marker_slot, frame_marker_enable, field_marker,
         shift_pulse_out, polarity_toggle_out, outside_clock_select}, {2'h3, 9'h000});
    chk({boost1_factor, bias_select, boost_clock_div, boost_amp_power, boost1_power, boost2_power, boost3_power,
         temp_coef_select, contrast_main, contrast_partial, low_power_hold},
        {14'h14c0, 4'h0, 2'h1, 16'h0, 1'b1});
    chk({no_dummy_subgroup, subgroup_invert, subgroup_phase_shift, row_vector_step, per_frame_invert,
         invert_block_count, half_frame_rate, frame_freq_select}, {5'h1f, 5'h0d, 1'b0, 4'h7});
    chk({wide_bus, memory_invert, column_reverse, row_reverse, row_first_count, read_modify_write_on, row_window_start,
         row_window_end, column_window_start, column_window_end}, {6'h00, 8'h00, 8'h83, 8'h00, 8'h83});
    chk({display_on, display_pattern, partial_on, partial_mode_sel, partial_dummy, partial_start, partial_end}, 0);
    chk({scroll_mode, scroll_start, scroll_end, low_fixed_lines, scroll_first_line, status_select,
         nv_trim_calibrate_on}, {10'h000, 8'h83, 16'h0000, 2'h0, 1'b1});
  endtask
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    hard_reset_low = 1'b1;
    subframe_head = 1'b0;
    subframe_index = 2'h0;
    pixel_load = 1'b0;
    pixel_word = 16'h8a5c;
    polarity_toggle_src = 1'b0;
    shift_pulse_src = 1'b1;
    field_marker_src = 1'b0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    defaults();
    $display("test reset done");
    for (int d = 0; d < 4; d++) begin
      u_host.put(1'b0, CMD_DRIVER, {d[0], 1'b1, d[1:0], 2'h3, d[1], d[0]}, 2);
      @(negedge mclk);
      chk({com_interleave, duty_select, com_scan_reverse, scan_line_count}, {d[0], d[1:0], d[0], 8'(96 + 12 * d)});
      chk(seg_color_exchange, (d == 3) ? 1 : 0);
      @(posedge mclk);
      subframe_head <= 1'b1;
      @(posedge mclk);
      subframe_head <= 1'b0;
      pixel_load <= 1'b1;
      @(posedge mclk);
      pixel_load <= 1'b0;
      @(negedge mclk);
      chk({seg_color_exchange, seg_a, seg_b, seg_c}, d[1] ? {1'b1, 16'he251} : {1'b0, 16'h8a5c});
    end
    $display("test driver done");
    for (int c = 0; c < 4; c++) begin
      u_host.put(1'b0, CMD_CLOCK, {6'h3f, c[1:0]}, 2);
      @(negedge mclk);
      chk({outside_clock_select, clock_source_running}, {c[1], 1'b0});
      if (!c[1]) chk(ring_clock_on, c[0]);
    end
    $display("test clock done");
    for (int s = 0; s < 4; s++) begin
      u_host.put(1'b0, CMD_MONITOR, {2'h3, s[1:0], 4'h8}, 2);
      for (int i = 0; i < 4; i++) begin
        @(posedge mclk);
        subframe_head <= 1'b1;
        subframe_index <= 2'(i);
        @(negedge mclk);
        chk({frame_marker_slot, frame_marker_out, observe_pin}, {s[1:0], i == s, i == s});
        @(posedge mclk);
        subframe_head <= 1'b0;
      end
    end
    for (int k = 0; k < 4; k++) begin
      u_host.put(1'b0, CMD_MONITOR, {4'h3, 4'hf << k}, 2);
      @(posedge mclk);
      subframe_head <= 1'b1;
      @(negedge mclk);
      chk({frame_marker_enable, field_marker, shift_pulse_out, polarity_toggle_out, observe_pin},
          {4'hf << k, k[0]});
      @(posedge mclk);
      subframe_head <= 1'b0;
    end
    $display("test monitor done");
    u_host.put(1'b0, CMD_NOP, 8'h00, 1);
    u_host.put(1'b1, CMD_DRIVER, 8'h00, 2);
    clk_en <= 1'b0;
    u_host.put(1'b0, CMD_DRIVER, 8'h00, 2);
    clk_en <= 1'b1;
    @(negedge mclk);
    chk({duty_select, com_scan_reverse, frame_marker_slot, frame_marker_enable}, {2'h3, 1'b1, 2'h3, 1'b1});
    $display("test refused done");
    @(posedge mclk);
    hard_reset_low <= 1'b0;
    @(posedge mclk);
    hard_reset_low <= 1'b1;
    @(negedge mclk);
    defaults();
    $display("test hard reset done");
    print_verdict();
  end
endmodule // lcd_config_command_core_test
`default_nettype wire

// *** inc/lcc_pkg.sv ***
// Package for the display configuration command core: command codes,
// parameter field positions and reset defaults.
// Assumes a byte-wide command/data bus with one write strobe per byte.
package lcc_pkg;
  // Command codes.
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_CLOCK    = 8'h02;
  localparam logic [7:0] CMD_DRIVER   = 8'h10;
  localparam logic [7:0] CMD_MONITOR  = 8'h18;

  // Parameter field positions.
  localparam int CLK_OUTSIDE_BIT   = 1;
  localparam int CLK_RING_BIT      = 0;
  localparam int DRV_INTERLEAVE_BIT = 7;
  localparam int DRV_DUTY_HI       = 5;
  localparam int DRV_DUTY_LO       = 4;
  localparam int DRV_EXCHANGE_BIT  = 1;
  localparam int DRV_REVERSE_BIT   = 0;
  localparam int MON_SLOT_HI       = 5;
  localparam int MON_SLOT_LO       = 4;
  localparam int MON_FRAME_BIT     = 3;
  localparam int MON_FIELD_BIT     = 2;
  localparam int MON_SHIFT_BIT     = 1;
  localparam int MON_POL_BIT       = 0;

  // Duty codes.
  localparam logic [1:0] DUTY_96  = 2'h0;
  localparam logic [1:0] DUTY_108 = 2'h1;
  localparam logic [1:0] DUTY_120 = 2'h2;
  localparam logic [1:0] DUTY_132 = 2'h3;
  localparam logic [7:0] LINES_96  = 8'h60;
  localparam logic [7:0] LINES_108 = 8'h6c;
  localparam logic [7:0] LINES_120 = 8'h78;
  localparam logic [7:0] LINES_132 = 8'h84;

  // Reset defaults.
  localparam logic [1:0] RST_DUTY        = DUTY_132;
  localparam logic [1:0] RST_SLOT        = 2'h0;
  localparam logic [3:0] RST_BOOST1      = 4'h5;
  localparam logic [3:0] RST_BIAS        = 4'h3;
  localparam logic [5:0] RST_BOOST_DIV   = 6'h00;
  localparam logic [1:0] RST_TEMP_COEF   = 2'h1;
  localparam logic [7:0] RST_CONTRAST    = 8'h00;
  localparam logic [4:0] RST_BLOCK_COUNT = 5'h0d;
  localparam logic [3:0] RST_FRAME_FREQ  = 4'h7;
  localparam logic [7:0] RST_START       = 8'h00;
  localparam logic [7:0] RST_END         = 8'h83;
  localparam logic [1:0] RST_PATTERN     = 2'h0;
  localparam logic [1:0] RST_SCROLL_MODE = 2'h0;
  localparam logic [1:0] RST_STATUS_SEL  = 2'h0;

  // Pixel word slices for the three segment groups.
  localparam int PIX_A_HI = 15;
  localparam int PIX_A_LO = 11;
  localparam int PIX_B_HI = 10;
  localparam int PIX_B_LO = 5;
  localparam int PIX_C_HI = 4;
  localparam int PIX_C_LO = 0;
  localparam int SUBFRAMES = 4;

  typedef enum logic [3:0] {
    LCC_IDLE    = 4'b0001,
    LCC_CLOCK   = 4'b0010,
    LCC_DRIVER  = 4'b0100,
    LCC_MONITOR = 4'b1000
  } lcc_state_t;
endpackage

// *** verilog/lcc_core.sv ***
// Configuration core: reset defaults of all configuration fields and the
// decoder of the no-operation, clock source, driver output and monitor commands.
// Assumes the host bus is already synchronous to mclk, one byte per strobe.
//
// Operation
// - Hard reset low forces every configuration field to its default.
// - Reset duty is 1/132; colour exchange and scan reverse clear.
// - Reset clears all monitor enables; frame marker slot points at first subframe.
// - Reset sets booster, bias, divider, power, temperature and contrast defaults.
// - Reset leaves the device in standby with low power hold set.
// - Reset sets subgroup, row vector, frame invert bits one; block count 01101.
// - Reset clears half frame rate; frame frequency select is 0111.
// - Reset clears every entry mode bit.
// - Reset window starts are zero; window ends are 10000011.
// - Reset turns display off, normal pattern, partial mode off and lines zero.
// - Reset selects whole screen scroll, scroll end 10000011, others zero.
// - Reset selects internal status for reads and enables trim calibration.
// - Command 00h is accepted and changes nothing.
// - Command 02h parameter: bit 1 outside clock, bit 0 oscillator on.
// - Outside clock or low power hold halts the oscillator; otherwise oscillator bit controls it.
// - Command 10h sets interleave, duty, colour exchange, scan reverse.
// - Duty codes pick 96 to 132 lines; unused commons rest at mid level.
// - Scan order maps halves upward, reversible, interleaved in groups of three.
// - Colour exchange swaps segment groups A and C bit ranges.
// - Command 18h sets slot and four monitor enables; disabled outputs ground.
// - Slot codes 00, 01, 10 pick first, second or third subframe.
// - Each contrast field is an 8-bit monotonic code from 0 to 255.
// - Slot code 11 picks the fourth subframe.
// - Shared monitor pin priority: polarity, shift, field, then frame marker.
`timescale 1ns/10ps
`default_nettype none
module lcc_core (
  // Clock, reset and enable
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                clk_en,
  input  wire logic                hard_reset_low,
  // Host byte writes
  input  wire logic                wr_strobe,
  input  wire logic                data_flag,
  input  wire logic [7:0]          wr_byte,
  // Timing events from the display timing generator
  input  wire logic                subframe_head,
  input  wire logic [1:0]          subframe_index,
  input  wire logic                polarity_toggle_src,
  input  wire logic                shift_pulse_src,
  input  wire logic                field_marker_src,
  // Pixel path
  input  wire logic [15:0]         pixel_word,
  input  wire logic                pixel_load,
  output logic [4:0]               seg_a,
  output logic [5:0]               seg_b,
  output logic [4:0]               seg_c,
  // Clock source control
  output logic                     outside_clock_select,
  output logic                     ring_clock_on,
  output logic                     clock_source_running,
  // Driver output settings
  output logic                     com_interleave,
  output logic [1:0]               duty_select,
  output logic                     seg_color_exchange,
  output logic                     com_scan_reverse,
  output logic [7:0]               scan_line_count,
  // Monitor outputs
  output logic [1:0]               frame_marker_slot,
  output logic                     frame_marker_enable,
  output logic                     field_marker,
  output logic                     shift_pulse_out,
  output logic                     polarity_toggle_out,
  output logic                     frame_marker_out,
  output logic                     observe_pin,
  // Fields of later commands, held at their defaults here
  output logic [3:0]               boost1_factor,
  output logic [3:0]               bias_select,
  output logic [5:0]               boost_clock_div,
  output logic                     boost_amp_power,
  output logic                     boost1_power,
  output logic                     boost2_power,
  output logic                     boost3_power,
  output logic [1:0]               temp_coef_select,
  output logic [7:0]               contrast_main,
  output logic [7:0]               contrast_partial,
  output logic                     low_power_hold,
  output logic                     no_dummy_subgroup,
  output logic                     subgroup_invert,
  output logic                     subgroup_phase_shift,
  output logic                     row_vector_step,
  output logic                     per_frame_invert,
  output logic [4:0]               invert_block_count,
  output logic                     half_frame_rate,
  output logic [3:0]               frame_freq_select,
  output logic                     wide_bus,
  output logic                     memory_invert,
  output logic                     column_reverse,
  output logic                     row_reverse,
  output logic                     row_first_count,
  output logic                     read_modify_write_on,
  output logic [7:0]               row_window_start,
  output logic [7:0]               row_window_end,
  output logic [7:0]               column_window_start,
  output logic [7:0]               column_window_end,
  output logic                     display_on,
  output logic [1:0]               display_pattern,
  output logic                     partial_on,
  output logic                     partial_mode_sel,
  output logic                     partial_dummy,
  output logic [7:0]               partial_start,
  output logic [7:0]               partial_end,
  output logic [1:0]               scroll_mode,
  output logic [7:0]               scroll_start,
  output logic [7:0]               scroll_end,
  output logic [7:0]               low_fixed_lines,
  output logic [7:0]               scroll_first_line,
  output logic [1:0]               status_select,
  output logic                     nv_trim_calibrate_on
);
  import lcc_pkg::*;

  lcc_state_t state;
  logic       cmd_wr;
  logic       par_wr;
  logic       any_reset;
  logic       seg_exchange_live;

  // The hard reset pin is synchronous, so it acts like a clocked clear.
  assign any_reset = !hard_reset_low;
  assign cmd_wr = clk_en && wr_strobe && !data_flag && (state == LCC_IDLE);
  assign par_wr = clk_en && wr_strobe && !data_flag && (state != LCC_IDLE);

  // A byte after a parameter-taking command is its parameter; NOP stays idle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= LCC_IDLE;
    end else if (clk_en) begin
      if (any_reset) begin
        state <= LCC_IDLE;
      end else if (cmd_wr) begin
        unique case (wr_byte)
          CMD_CLOCK:   state <= LCC_CLOCK;
          CMD_DRIVER:  state <= LCC_DRIVER;
          CMD_MONITOR: state <= LCC_MONITOR;
          default:     state <= LCC_IDLE;
        endcase
      end else if (par_wr) begin
        state <= LCC_IDLE;
      end
    end
  end

  // Clock source: bits other than the two defined ones are dropped.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      outside_clock_select <= 1'b0;
      ring_clock_on        <= 1'b0;
    end else if (clk_en) begin
      if (any_reset) begin
        outside_clock_select <= 1'b0;
        ring_clock_on        <= 1'b0;
      end else if (par_wr && state == LCC_CLOCK) begin
        outside_clock_select <= wr_byte[CLK_OUTSIDE_BIT];
        ring_clock_on        <= wr_byte[CLK_RING_BIT];
      end
    end
  end
  // The outside clock overrides the oscillator bit; standby also stops it.
  assign clock_source_running = !outside_clock_select && ring_clock_on && !low_power_hold;

  // Driver output mode.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      com_interleave     <= 1'b0;
      duty_select        <= RST_DUTY;
      seg_exchange_live  <= 1'b0;
      com_scan_reverse   <= 1'b0;
    end else if (clk_en) begin
      if (any_reset) begin
        com_interleave     <= 1'b0;
        duty_select        <= RST_DUTY;
        seg_exchange_live  <= 1'b0;
        com_scan_reverse   <= 1'b0;
      end else if (par_wr && state == LCC_DRIVER) begin
        com_interleave     <= wr_byte[DRV_INTERLEAVE_BIT];
        duty_select        <= wr_byte[DRV_DUTY_HI:DRV_DUTY_LO];
        seg_exchange_live  <= wr_byte[DRV_EXCHANGE_BIT];
        com_scan_reverse   <= wr_byte[DRV_REVERSE_BIT];
      end
    end
  end

  // Colour exchange is not immediate: it takes effect at the next subframe head
  // so a pixel row is never split between two mappings.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seg_color_exchange <= 1'b0;
    end else if (clk_en) begin
      if (any_reset) begin
        seg_color_exchange <= 1'b0;
      end else if (subframe_head) begin
        seg_color_exchange <= seg_exchange_live;
      end
    end
  end

  // Lines scanned for the chosen duty; the rest rest at the mid level.
  always_comb begin
    unique case (duty_select)
      DUTY_96:  scan_line_count = LINES_96;
      DUTY_108: scan_line_count = LINES_108;
      DUTY_120: scan_line_count = LINES_120;
      DUTY_132: scan_line_count = LINES_132;
    endcase
  end

  // Segment data registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seg_a <= 5'h00;
      seg_b <= 6'h00;
      seg_c <= 5'h00;
    end else if (clk_en && pixel_load) begin
      seg_b <= pixel_word[PIX_B_HI:PIX_B_LO];
      if (seg_color_exchange) begin
        seg_a <= pixel_word[PIX_C_HI:PIX_C_LO];
        seg_c <= pixel_word[PIX_A_HI:PIX_A_LO];
      end else begin
        seg_a <= pixel_word[PIX_A_HI:PIX_A_LO];
        seg_c <= pixel_word[PIX_C_HI:PIX_C_LO];
      end
    end
  end

  // Monitor control.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frame_marker_slot   <= RST_SLOT;
      frame_marker_enable <= 1'b0;
      field_marker        <= 1'b0;
      shift_pulse_out     <= 1'b0;
      polarity_toggle_out <= 1'b0;
    end else if (clk_en) begin
      if (any_reset) begin
        frame_marker_slot   <= RST_SLOT;
        frame_marker_enable <= 1'b0;
        field_marker        <= 1'b0;
        shift_pulse_out     <= 1'b0;
        polarity_toggle_out <= 1'b0;
      end else if (par_wr && state == LCC_MONITOR) begin
        frame_marker_slot   <= wr_byte[MON_SLOT_HI:MON_SLOT_LO];
        frame_marker_enable <= wr_byte[MON_FRAME_BIT];
        field_marker        <= wr_byte[MON_FIELD_BIT];
        shift_pulse_out     <= wr_byte[MON_SHIFT_BIT];
        polarity_toggle_out <= wr_byte[MON_POL_BIT];
      end
    end
  end

  // The frame marker pulses at the head of the selected subframe only.
  assign frame_marker_out = frame_marker_enable && subframe_head
                            && (subframe_index == frame_marker_slot);

  // Shared pin: first enabled source in priority order; all disabled is ground.
  always_comb begin
    if (polarity_toggle_out) begin
      observe_pin = polarity_toggle_src;
    end else if (shift_pulse_out) begin
      observe_pin = shift_pulse_src;
    end else if (field_marker) begin
      observe_pin = field_marker_src;
    end else if (frame_marker_enable) begin
      observe_pin = frame_marker_out;
    end else begin
      observe_pin = 1'b0;
    end
  end

  // Fields of later commands: only reset here, no command writes them yet.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      boost1_factor        <= RST_BOOST1;
      bias_select          <= RST_BIAS;
      boost_clock_div      <= RST_BOOST_DIV;
      {boost_amp_power, boost1_power, boost2_power, boost3_power} <= 4'h0;
      temp_coef_select     <= RST_TEMP_COEF;
      contrast_main        <= RST_CONTRAST;
      contrast_partial     <= RST_CONTRAST;
      low_power_hold       <= 1'b1;
      {no_dummy_subgroup, subgroup_invert, subgroup_phase_shift} <= 3'h7;
      row_vector_step      <= 1'b1;
      per_frame_invert     <= 1'b1;
      invert_block_count   <= RST_BLOCK_COUNT;
      half_frame_rate      <= 1'b0;
      frame_freq_select    <= RST_FRAME_FREQ;
      {wide_bus, memory_invert, column_reverse, row_reverse} <= 4'h0;
      {row_first_count, read_modify_write_on} <= 2'h0;
      row_window_start     <= RST_START;
      row_window_end       <= RST_END;
      column_window_start  <= RST_START;
      column_window_end    <= RST_END;
      display_on           <= 1'b0;
      display_pattern      <= RST_PATTERN;
      {partial_on, partial_mode_sel, partial_dummy} <= 3'h0;
      partial_start        <= RST_START;
      partial_end          <= RST_START;
      scroll_mode          <= RST_SCROLL_MODE;
      scroll_start         <= RST_START;
      scroll_end           <= RST_END;
      low_fixed_lines      <= RST_START;
      scroll_first_line    <= RST_START;
      status_select        <= RST_STATUS_SEL;
      nv_trim_calibrate_on <= 1'b1;
    end else if (clk_en && any_reset) begin
      boost1_factor        <= RST_BOOST1;
      bias_select          <= RST_BIAS;
      boost_clock_div      <= RST_BOOST_DIV;
      {boost_amp_power, boost1_power, boost2_power, boost3_power} <= 4'h0;
      temp_coef_select     <= RST_TEMP_COEF;
      contrast_main        <= RST_CONTRAST;
      contrast_partial     <= RST_CONTRAST;
      low_power_hold       <= 1'b1;
      {no_dummy_subgroup, subgroup_invert, subgroup_phase_shift} <= 3'h7;
      row_vector_step      <= 1'b1;
      per_frame_invert     <= 1'b1;
      invert_block_count   <= RST_BLOCK_COUNT;
      half_frame_rate      <= 1'b0;
      frame_freq_select    <= RST_FRAME_FREQ;
      {wide_bus, memory_invert, column_reverse, row_reverse} <= 4'h0;
      {row_first_count, read_modify_write_on} <= 2'h0;
      row_window_start     <= RST_START;
      row_window_end       <= RST_END;
      column_window_start  <= RST_START;
      column_window_end    <= RST_END;
      display_on           <= 1'b0;
      display_pattern      <= RST_PATTERN;
      {partial_on, partial_mode_sel, partial_dummy} <= 3'h0;
      partial_start        <= RST_START;
      partial_end          <= RST_START;
      scroll_mode          <= RST_SCROLL_MODE;
      scroll_start         <= RST_START;
      scroll_end           <= RST_END;
      low_fixed_lines      <= RST_START;
      scroll_first_line    <= RST_START;
      status_select        <= RST_STATUS_SEL;
      nv_trim_calibrate_on <= 1'b1;
    end
  end

  // Assertions.
  sequence clock_cmd_s;
    cmd_wr && wr_byte == CMD_CLOCK;
  endsequence
  sequence param_s;
    par_wr && !any_reset;
  endsequence

  hard_reset_defaults_a: assert property (@(posedge mclk) disable iff (rst)
    clk_en && any_reset |=> duty_select == RST_DUTY && low_power_hold && !polarity_toggle_out)
    else $error("hard reset did not restore defaults");
  duty_default_a: assert property (@(posedge mclk) disable iff (rst)
    clk_en && any_reset |=> scan_line_count == LINES_132 && !com_scan_reverse)
    else $error("duty default wrong");
  monitor_ground_a: assert property (@(posedge mclk) disable iff (rst)
    !polarity_toggle_out && !shift_pulse_out && !field_marker && !frame_marker_enable |-> !observe_pin)
    else $error("monitor pin not at ground");
  nop_no_change_a: assert property (@(posedge mclk) disable iff (rst)
    cmd_wr && wr_byte == CMD_NOP && !any_reset |=> state == LCC_IDLE && $stable(duty_select))
    else $error("nop changed state");
  clock_param_a: assert property (@(posedge mclk) disable iff (rst)
    clock_cmd_s ##1 param_s
    |=> outside_clock_select == $past(wr_byte[CLK_OUTSIDE_BIT]) && ring_clock_on == $past(wr_byte[CLK_RING_BIT]))
    else $error("clock parameter not latched");
  outside_halts_a: assert property (@(posedge mclk) disable iff (rst)
    outside_clock_select |-> !clock_source_running)
    else $error("oscillator runs with outside clock");
  exchange_deferred_a: assert property (@(posedge mclk) disable iff (rst)
    clk_en && !subframe_head && !any_reset |=> $stable(seg_color_exchange))
    else $error("colour exchange changed mid subframe");
  slot_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    frame_marker_out |-> subframe_head && subframe_index == frame_marker_slot)
    else $error("frame marker in wrong subframe");
  pin_priority_a: assert property (@(posedge mclk) disable iff (rst)
    polarity_toggle_out |-> observe_pin == polarity_toggle_src)
    else $error("monitor pin priority wrong");
  other_fields_a: assert property (@(posedge mclk) disable iff (rst)
    param_s ##0 (state == LCC_MONITOR) |=> $stable(duty_select) && $stable(ring_clock_on))
    else $error("monitor write touched other fields");
endmodule // lcc_core
`default_nettype wire
